/* File: hw/dsi_consts.vh */
// How it works
// - spin switch at unload enables disk-stopped counter and drops run gate
// - rotation marks clear the disk-stopped counter before it reaches two
// - run low clears start delay, drops head load until count is eight
// - losing head load resets ready and lets the positioner retract heads
// - heads home resets the spindle motor latch so the disk coasts down
// - without marks, slow ticks take counter to two; hold, unlock, light
// - each index pulse retriggers a 45 ms low-speed one-shot, on-speed set
// - index gap beyond one-shot expires it, clears on-speed, drops head load
// - head load lost on low speed fires a 40 us strobe clearing start delay
// - ac presence retriggers a 45 ms one-shot; timeout asserts mains fail
// - after mains fail, next sector pulse resets the low-speed one-shot
// - supply good low drops run, releases safety relay, flags supply fail
// - binary select mode decodes 3-bit code one-of-eight, linear lines off
// - high density variant joins unit positions in four pairs
// - select match and ready and no fault form selected-and-ready
// - linear mode maps four select lines to unit positions 0 to 3
// - slow clock gives one pulse each second
// - head load only with on-speed set and start delay at terminal count
`ifndef DSI_CONSTS_VH
`define DSI_CONSTS_VH

// clock and times, in nanoseconds
`define DSI_CLK_NS        5
`define DSI_SLOW_NS       1000000000
`define DSI_LOWSPD_NS     45000000
`define DSI_ACDET_NS      45000000
`define DSI_STROBE_NS     40000

// counter terminal values
`define DSI_START_DONE    4'h8
`define DSI_STOP_DONE     2'h2

// register byte offsets
`define DSI_OFS_CTRL      8'h00
`define DSI_OFS_STATUS    8'h04
`define DSI_OFS_IRQ_STAT  8'h08
`define DSI_OFS_IRQ_EN    8'h0C
`define DSI_OFS_IRQ_CLR   8'h10

// reset values
`define DSI_CTRL_RST      1'h0
`define DSI_IRQ_EN_RST    5'h00

// interrupt status bit positions
`define DSI_IRQ_MAINS     0
`define DSI_IRQ_SUPPLY    1
`define DSI_IRQ_LOWSPD    2
`define DSI_IRQ_DOOR      3
`define DSI_IRQ_READY     4
`define DSI_IRQ_W         5

`endif

/* File: hw/dsi_top.v */
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "dsi_consts.vh"

module dsi_top #(
    parameter integer SLOW_CYC   = `DSI_SLOW_NS / `DSI_CLK_NS,
    parameter integer LOWSPD_CYC = `DSI_LOWSPD_NS / `DSI_CLK_NS,
    parameter integer ACDET_CYC  = `DSI_ACDET_NS / `DSI_CLK_NS,
    parameter integer STROBE_CYC = `DSI_STROBE_NS / `DSI_CLK_NS
) (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // ahb-lite slave
    input  wire        hsel_in,
    input  wire [7:0]  haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output reg         hreadyout_out,
    output reg         hresp_out,
    // drive pins
    input  wire        run_switch_in,
    input  wire        index_in,
    input  wire        sector_in,
    input  wire        ac_present_in,
    input  wire        supply_good_in,
    input  wire        heads_home_in,
    input  wire        on_cyl_in,
    input  wire        fault_in,
    input  wire        binary_select_mode_n_in,
    input  wire [3:0]  drive_select_lines_in,
    input  wire [2:0]  unit_address_switch_in,
    output reg         run_n_out,
    output reg         head_load_out,
    output reg         ready_out,
    output reg         spindle_on_out,
    output reg         door_unlock_out,
    output reg         unload_lamp_out,
    output reg         stop_strobe_out,
    output reg         mains_fail_out,
    output reg         supply_fail_out,
    output reg         safety_relay_out,
    output reg         sel_ready_out,
    output reg         irq_out
);

    // behaviour in brief
    // every drive pin is sampled on each rising clock edge
    // every output is a flip-flop, so a cause shows one cycle later
    // counters that feed an output add one more cycle of latency
    //
    // run gate
    // the run gate is the switch at run and a good supply together
    // losing either drops the gate at once, with no filtering
    // a bouncing switch therefore toggles the gate cycle by cycle
    // the start delay counter is cleared whenever the gate is low
    //
    // start delay
    // counts slow ticks up to eight while the gate is high
    // it holds at eight, so head load stays allowed
    // the stop strobe clears it again after a low speed stop
    // the heads must then wait eight ticks, at least seven full periods, before reloading
    // the first tick after a clear may come at any phase
    //
    // speed supervision
    // the low speed one-shot is reloaded by each index pulse
    // while it is running the drive counts as on speed
    // if index pulses stop it runs out and head load drops
    // the set value must exceed the nominal index spacing
    // a pulse longer than one cycle simply reloads it again
    //
    // stop strobe
    // fires when head load falls while the drive is not on speed
    // a normal stop by the switch does not fire it
    // its length is a fixed number of cycles, not retriggered
    //
    // spindle latch
    // set on the rising edge of the run gate
    // a stop is remembered until the heads reach home
    // once home, the latch clears and the disk coasts down
    // a new rising run gate cancels a pending stop
    // heads resting at home while running do not stop the spindle
    //
    // disk stopped counter
    // live only while the switch is at unload
    // any index or sector mark clears it, so a turning disk
    // never unlocks the door
    // two slow ticks with no mark in between unlock the door
    // the count then holds, and the unload lamp follows the door
    //
    // power supervision
    // the ac one-shot is reloaded while ac is present
    // it starts empty, so mains fail pulses once after reset
    // after mains fail, the next sector mark empties the
    // low speed one-shot, ending the transfer on a sector boundary
    // a sector mark wins over an index pulse in the same cycle
    // a bad supply drops the run gate, opens the safety relay
    // and raises supply fail, all in the same cycle
    //
    // unit select
    // binary mode decodes a three bit code to one of eight units
    // linear mode maps four lines straight onto units zero to three
    // units four to seven are never chosen in linear mode
    // the pairing bit joins each unit with its bit zero neighbour
    // the match is gated with ready and the absence of a fault
    //
    // register bus
    // single word transfers only, no wait states, always okay
    // read data is driven for one cycle, zero otherwise
    // writes land at the end of the data phase
    // a status event in the same cycle as a clear still sets
    // the interrupt output follows status one cycle later
    // hsize is ignored; every register is one aligned word
    //
    // limitations
    // the time base counters are wide enough for real timings
    // tests shorten them through the parameters
    // nothing here retracts heads itself; head load only gates it
    // no pin is filtered; glitches reach the counters directly


    // unit match for either select mode, with optional pairing
    function sel_match;
        input       bin_mode;
        input       hd;
        input [3:0] lines;
        input [2:0] unit;
        reg   [7:0] dec;
        reg   [2:0] mate;
        begin
            dec = 8'h00;
            mate = {unit[2:1], ~unit[0]};
            if (bin_mode) begin
                dec[lines[2:0]] = 1'b1;
            end else begin
                dec[3:0] = lines;
            end
            sel_match = dec[unit] | (hd & dec[mate]);
        end
    endfunction

    reg  [31:0] slow_cnt_r;
    reg         slow_tick_r;
    reg  [3:0]  start_cnt_r;
    reg  [1:0]  stop_cnt_r;
    reg  [31:0] lowspd_cnt_r;
    reg  [31:0] acdet_cnt_r;
    reg  [31:0] strobe_cnt_r;
    reg         stop_pend_r;
    reg         run_en_d_r;
    reg         ctrl_hd_r;
    reg  [4:0]  irq_stat_r;
    reg  [4:0]  irq_en_r;
    reg  [4:0]  ev_prev_r;
    reg         dph_wr_r;
    reg  [7:0]  dph_addr_r;

    wire        run_en;
    wire        on_speed;
    wire        load_ok;
    wire        rot_mark;
    wire        ac_ok;
    wire [4:0]  ev_now;
    wire [4:0]  ev_rise;
    wire        ahb_go;
    wire [4:0]  clr_mask;

    // run gate needs switch at run and good supply
    assign run_en   = run_switch_in & supply_good_in;
    assign on_speed = (lowspd_cnt_r != 32'h0);
    assign load_ok  = run_en & on_speed &
                      (start_cnt_r == `DSI_START_DONE);
    assign rot_mark = index_in | sector_in;
    assign ac_ok    = (acdet_cnt_r != 32'h0);
    assign ev_now   = {ready_out, door_unlock_out, ~on_speed,
                       supply_fail_out, mains_fail_out};
    assign ev_rise  = ev_now & ~ev_prev_r;
    assign ahb_go   = hsel_in & htrans_in[1] & hready_in;
    assign clr_mask = (dph_wr_r && dph_addr_r == `DSI_OFS_IRQ_CLR) ?
                      hwdata_in[4:0] : 5'h00;

    // one pulse per second time base
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            slow_cnt_r  <= 32'h0;
            slow_tick_r <= 1'b0;
        end else if (slow_cnt_r == SLOW_CYC - 1) begin
            slow_cnt_r  <= 32'h0;
            slow_tick_r <= 1'b1;
        end else begin
            slow_cnt_r  <= slow_cnt_r + 32'h1;
            slow_tick_r <= 1'b0;
        end
    end

    // start delay counter, saturating at eight
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            start_cnt_r <= 4'h0;
        end else if (!run_en || stop_strobe_out) begin
            start_cnt_r <= 4'h0;
        end else if (slow_tick_r &&
                     start_cnt_r != `DSI_START_DONE) begin
            start_cnt_r <= start_cnt_r + 4'h1;
        end
    end

    // disk stopped counter, live only with switch at unload
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stop_cnt_r <= 2'h0;
        end else if (run_switch_in) begin
            stop_cnt_r <= 2'h0;
        end else if (rot_mark) begin
            stop_cnt_r <= 2'h0;
        end else if (slow_tick_r && stop_cnt_r != `DSI_STOP_DONE) begin
            stop_cnt_r <= stop_cnt_r + 2'h1;
        end
    end

    // low speed timeout one-shot, retriggered by index
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lowspd_cnt_r <= 32'h0;
        end else if (mains_fail_out && sector_in) begin
            lowspd_cnt_r <= 32'h0;
        end else if (index_in) begin
            lowspd_cnt_r <= LOWSPD_CYC;
        end else if (lowspd_cnt_r != 32'h0) begin
            lowspd_cnt_r <= lowspd_cnt_r - 32'h1;
        end
    end

    // ac detect one-shot, retriggered while ac is present
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            acdet_cnt_r <= 32'h0;
        end else if (ac_present_in) begin
            acdet_cnt_r <= ACDET_CYC;
        end else if (acdet_cnt_r != 32'h0) begin
            acdet_cnt_r <= acdet_cnt_r - 32'h1;
        end
    end

    // stop strobe fires when head load drops for low speed
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            strobe_cnt_r <= 32'h0;
        end else if (head_load_out && !load_ok && !on_speed) begin
            strobe_cnt_r <= STROBE_CYC;
        end else if (strobe_cnt_r != 32'h0) begin
            strobe_cnt_r <= strobe_cnt_r - 32'h1;
        end
    end

    // spindle latch: on at run, off once heads are home after a stop
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_en_d_r     <= 1'b0;
            stop_pend_r    <= 1'b0;
            spindle_on_out <= 1'b0;
        end else begin
            run_en_d_r <= run_en;
            if (run_en && !run_en_d_r) begin
                stop_pend_r    <= 1'b0;
                spindle_on_out <= 1'b1;
            end else if (stop_pend_r && heads_home_in) begin
                stop_pend_r    <= 1'b0;
                spindle_on_out <= 1'b0;
            end else if (head_load_out && !load_ok) begin
                stop_pend_r <= 1'b1;
            end else if (!run_en && spindle_on_out) begin
                stop_pend_r <= 1'b1;
            end
        end
    end

    // drive control outputs
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_n_out        <= 1'b1;
            head_load_out    <= 1'b0;
            ready_out        <= 1'b0;
            door_unlock_out  <= 1'b0;
            unload_lamp_out  <= 1'b0;
            stop_strobe_out  <= 1'b0;
            mains_fail_out   <= 1'b0;
            supply_fail_out  <= 1'b0;
            safety_relay_out <= 1'b0;
            sel_ready_out    <= 1'b0;
        end else begin
            run_n_out        <= ~run_en;
            head_load_out    <= load_ok;
            if (!load_ok) begin
                ready_out <= 1'b0;
            end else if (on_cyl_in) begin
                ready_out <= 1'b1;
            end
            door_unlock_out  <= (stop_cnt_r == `DSI_STOP_DONE);
            unload_lamp_out  <= (stop_cnt_r == `DSI_STOP_DONE);
            stop_strobe_out  <= (strobe_cnt_r != 32'h0);
            mains_fail_out   <= ~ac_ok;
            supply_fail_out  <= ~supply_good_in;
            safety_relay_out <= supply_good_in;
            sel_ready_out    <= sel_match(~binary_select_mode_n_in,
                                    ctrl_hd_r, drive_select_lines_in,
                                    unit_address_switch_in) &
                                ready_out & ~fault_in;
        end
    end

    // sticky interrupt status; a new event wins over a clear
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ev_prev_r  <= 5'h00;
            irq_stat_r <= 5'h00;
            irq_out    <= 1'b0;
        end else begin
            ev_prev_r  <= ev_now;
            irq_stat_r <= (irq_stat_r & ~clr_mask) | ev_rise;
            irq_out    <= |(irq_stat_r & irq_en_r);
        end
    end

    // ahb-lite slave: zero wait, always okay
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dph_wr_r      <= 1'b0;
            dph_addr_r    <= 8'h00;
            hrdata_out    <= 32'h0;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            dph_wr_r      <= ahb_go & hwrite_in;
            dph_addr_r    <= haddr_in;
            hrdata_out    <= 32'h0;
            if (ahb_go && !hwrite_in) begin
                case (haddr_in)
                    `DSI_OFS_CTRL: begin
                        hrdata_out <= {31'h0, ctrl_hd_r};
                    end
                    `DSI_OFS_STATUS: begin
                        hrdata_out <= {16'h0, start_cnt_r, stop_cnt_r,
                                       on_speed, spindle_on_out,
                                       sel_ready_out, supply_fail_out,
                                       mains_fail_out, door_unlock_out,
                                       ready_out, head_load_out,
                                       run_n_out, stop_strobe_out};
                    end
                    `DSI_OFS_IRQ_STAT: begin
                        hrdata_out <= {27'h0, irq_stat_r};
                    end
                    `DSI_OFS_IRQ_EN: begin
                        hrdata_out <= {27'h0, irq_en_r};
                    end
                    default: begin
                        hrdata_out <= 32'h0;
                    end
                endcase
            end
        end
    end

    // register writes in the data phase
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_hd_r <= `DSI_CTRL_RST;
            irq_en_r  <= `DSI_IRQ_EN_RST;
        end else if (dph_wr_r) begin
            if (dph_addr_r == `DSI_OFS_CTRL) begin
                ctrl_hd_r <= hwdata_in[0];
            end
            if (dph_addr_r == `DSI_OFS_IRQ_EN) begin
                irq_en_r <= hwdata_in[4:0];
            end
        end
    end

endmodule // dsi_top

/* File: test/dsi_props.sv */
`timescale 1ns/1ps
module dsi_props #(
    parameter integer STROBE_CYC = 4
) (
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    input wire logic       run_switch_in,
    input wire logic       index_in,
    input wire logic       sector_in,
    input wire logic       ac_present_in,
    input wire logic       supply_good_in,
    input wire logic       heads_home_in,
    input wire logic       fault_in,
    input wire logic       binary_select_mode_n_in,
    input wire logic [3:0] drive_select_lines_in,
    input wire logic       run_n_out,
    input wire logic       head_load_out,
    input wire logic       ready_out,
    input wire logic       spindle_on_out,
    input wire logic       door_unlock_out,
    input wire logic       unload_lamp_out,
    input wire logic       stop_strobe_out,
    input wire logic       mains_fail_out,
    input wire logic       supply_fail_out,
    input wire logic       safety_relay_out,
    input wire logic       sel_ready_out
);
    integer stb_cnt_r;
    // length of the current stop strobe
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stb_cnt_r <= 0;
        end else begin
            stb_cnt_r <= stop_strobe_out ? stb_cnt_r + 1 : 0;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // stop sequence
    a_unload_run: assert property (!run_switch_in |=> run_n_out)
        else $error("run not dropped on unload");
    a_mark_clear: assert property ((index_in || sector_in) |->
        ##[1:2] !door_unlock_out) else $error("door open while turning");
    a_run_hl: assert property ($rose(run_n_out) |->
        ##[0:1] !head_load_out) else $error("head load kept after stop");
    a_ready_drop: assert property ($fell(head_load_out) |->
        ##[0:1] !ready_out) else $error("ready kept after unload");
    a_spin_stop: assert property ((heads_home_in && run_n_out
        && !run_switch_in)[*3] |-> !spindle_on_out)
        else $error("spindle kept at home");
    a_unlock_hold: assert property ((door_unlock_out && !run_switch_in
        && !index_in && !sector_in)[*2] |=> door_unlock_out)
        else $error("door unlock not held");
    a_door_lamp: assert property (door_unlock_out == unload_lamp_out)
        else $error("lamp differs from door");
    // speed, power and select
    a_strobe_len: assert property ($fell(stop_strobe_out) |->
        stb_cnt_r == STROBE_CYC) else $error("stop strobe length");
    a_strobe_why: assert property ($rose(stop_strobe_out) |->
        !head_load_out) else $error("strobe without unload");
    a_mains_ok: assert property (ac_present_in[*3] |=>
        !mains_fail_out) else $error("mains fail with ac present");
    a_dc_stop: assert property ($fell(supply_good_in) |=>
        supply_fail_out && !safety_relay_out ##[0:1] run_n_out)
        else $error("supply drop not handled");
    a_fault_sel: assert property (fault_in |=> !sel_ready_out)
        else $error("selected with fault");
    a_lin_none: assert property (binary_select_mode_n_in &&
        drive_select_lines_in == 4'h0 |=> !sel_ready_out)
        else $error("selected with no line");
    a_hl_rise: assert property ($rose(head_load_out) |-> !run_n_out)
        else $error("head load without run");
endmodule // dsi_props
bind dsi_top dsi_props #(.STROBE_CYC(STROBE_CYC)) dsi_props_i (.*);

/* File: test/dsi_ctl_model.sv */
`timescale 1ns/1ps
module dsi_ctl_model (
    input  wire logic       clk_in,
    input  wire logic       bin_in,
    input  wire logic [3:0] sel_in,
    output reg        mode_n_out = 1'b1,
    output reg  [3:0] lines_out = 4'h0
);
    // present the chosen drive code in binary or linear form
    always @(posedge clk_in) begin
        mode_n_out <= ~bin_in;
        lines_out  <= bin_in ? {1'b0, sel_in[2:0]} : sel_in;
    end
endmodule // dsi_ctl_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int SC = 50;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, hsel_in = 1'b0;
    logic hwrite_in = 1'b0, run_switch_in = 1'b0, index_in = 1'b0;
    logic sector_in = 1'b0, ac_present_in = 1'b1, supply_good_in = 1'b1;
    logic heads_home_in = 1'b1, on_cyl_in = 1'b0, fault_in = 1'b0;
    logic want_bin = 1'b0, idx_on = 1'b0;
    logic [1:0] htrans_in = 2'h0;
    logic [2:0] hsize_in = 3'h2, unit_address_switch_in = 3'h0;
    logic [3:0] want_sel = 4'h0;
    logic [7:0] haddr_in = 8'h00;
    logic [31:0] hwdata_in = 32'h0, q;
    wire logic [31:0] hrdata_out;
    wire logic [3:0] drive_select_lines_in;
    wire logic hready_in, hreadyout_out, hresp_out, binary_select_mode_n_in;
    wire logic run_n_out, head_load_out, ready_out, spindle_on_out, irq_out;
    wire logic door_unlock_out, unload_lamp_out, stop_strobe_out;
    wire logic mains_fail_out, supply_fail_out, safety_relay_out;
    wire logic sel_ready_out;
    int n_errors = 0, total_checks = 0, cyc = 0, i, k;
    assign hready_in = hreadyout_out;
    dsi_top #(.SLOW_CYC(SC), .LOWSPD_CYC(30), .ACDET_CYC(30),
        .STROBE_CYC(4)) dsi_top_i (.*);
    dsi_ctl_model dsi_ctl_model_i (.clk_in(ref_clk_in), .bin_in(want_bin),
        .sel_in(want_sel), .mode_n_out(binary_select_mode_n_in),
        .lines_out(drive_select_lines_in));
    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    // index every 20 cycles while turning, and the run limit
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        index_in <= idx_on && (cyc % 20 == 0);
        if (cyc == 40000) begin
            n_errors++;
            wrap_up();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // one single bus transfer; read data lands in q
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in <= a;
        hwrite_in <= w;
        tick(1);
        while (hready_in !== 1'b1) tick(1);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        tick(1);
        while (hready_in !== 1'b1) tick(1);
        q = hrdata_out;
        chk("hresp", 0, hresp_out);
    endtask
    task t_start;
        run_switch_in <= 1'b1;
        idx_on <= 1'b1;
        tick(6);
        chk("run_n", 0, run_n_out);
        chk("spindle", 1, spindle_on_out);
        for (i = 0; i < 700 && head_load_out !== 1'b1; i++) tick(1);
        chk("load_time", 1, i >= 7 * SC - 10 && i <= 8 * SC + 9);
        on_cyl_in <= 1'b1;
        heads_home_in <= 1'b0;
        tick(3);
        chk("ready", 1, ready_out);
    endtask
    task t_sel;
        unit_address_switch_in <= 3'h5;
        for (k = 0; k < 16; k++) begin
            ahb(1'b1, 8'h00, 32'(k / 8));
            want_bin <= 1'b1;
            want_sel <= 4'(k % 8);
            tick(4);
            chk("sel_bin", (k < 8) ? k == 5 : k % 8 / 2 == 2, sel_ready_out);
        end
        unit_address_switch_in <= 3'h2;
        ahb(1'b1, 8'h00, 32'h0);
        for (k = 0; k < 4; k++) begin
            want_bin <= 1'b0;
            want_sel <= 4'h1 << k;
            tick(4);
            chk("sel_lin", k == 2, sel_ready_out);
        end
        fault_in <= 1'b1;
        tick(3);
        chk("sel_fault", 0, sel_ready_out);
        fault_in <= 1'b0;
    endtask
    task t_low;
        ahb(1'b1, 8'h10, 32'h1F);
        ahb(1'b1, 8'h0C, 32'h4);
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 0, q);
        chk("irq_idle", 0, irq_out);
        idx_on <= 1'b0;
        for (i = 0; i < 60 && stop_strobe_out !== 1'b1; i++) tick(1);
        chk("hl_low", 0, head_load_out);
        chk("strobe", 1, stop_strobe_out);
        tick(3);
        chk("irq", 1, irq_out);
        ahb(1'b1, 8'h0C, 32'h0);
        tick(2);
        chk("irq_mask", 0, irq_out);
        ahb(1'b1, 8'h10, 32'h4);
        ahb(1'b0, 8'h08, 32'h0);
        chk("stat_clr", 0, q[2]);
        idx_on <= 1'b1;
        for (i = 0; i < 700 && head_load_out !== 1'b1; i++) tick(1);
        chk("reload", 1, i >= 7 * SC - 25 && i < 700);
    endtask
    task t_power;
        ac_present_in <= 1'b0;
        for (i = 0; i < 60 && mains_fail_out !== 1'b1; i++) tick(1);
        chk("ac_time", 1, i >= 25 && i <= 40);
        while (index_in !== 1'b1) tick(1);
        chk("hl_hold", 1, head_load_out);
        sector_in <= 1'b1;
        tick(1);
        sector_in <= 1'b0;
        tick(5);
        chk("hl_sector", 0, head_load_out);
        ac_present_in <= 1'b1;
        supply_good_in <= 1'b0;
        tick(3);
        chk("dc_run", 1, run_n_out);
        chk("dc_flag", 1, supply_fail_out);
        chk("dc_relay", 0, safety_relay_out);
        supply_good_in <= 1'b1;
    endtask
    task t_stop;
        tick(10);
        run_switch_in <= 1'b0;
        tick(3);
        chk("stop_run", 1, run_n_out);
        heads_home_in <= 1'b1;
        tick(4);
        chk("coast", 0, spindle_on_out);
        tick(4 * SC);
        chk("door_turn", 0, door_unlock_out);
        idx_on <= 1'b0;
        tick(3 * SC + 5);
        chk("door", 1, door_unlock_out);
        tick(2 * SC);
        chk("lamp", 1, unload_lamp_out);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        tick(12);
        rst_in <= 1'b0;
        tick(1);
        t_start();
        t_sel();
        t_low();
        t_power();
        t_stop();
        wrap_up();
    end
endmodule // tb_top
